/* File: include/dma_pkg.sv */
// constants and state codes for the transfer controller
// assumes one 50 MHz system clock and single-cycle trigger pulses from peripherals
package dma_pkg;
    localparam int NUM_CH  = 4;           // independent channels 0..3
    localparam int ADDR_W  = 26;          // full transfer address width
    localparam int CNT_W   = 16;          // transfer count width
    localparam int DATA_W  = 16;          // bus data width
    localparam int TRIG_W  = 6;           // trigger factor field width
    localparam int CTRL_W  = 16;          // addressing control word width

    // addressing control layout; every other bit is reserved and ignored
    localparam int CTRL_WIDE_BIT = 14;    // 1: 16-bit transfers, 0: 8-bit
    localparam int CTRL_SRC_HI   = 7;     // source step mode msb
    localparam int CTRL_SRC_LO   = 6;     // source step mode lsb
    localparam int CTRL_DST_HI   = 5;     // destination step mode msb
    localparam int CTRL_DST_LO   = 4;     // destination step mode lsb

    // step modes
    localparam logic [1:0] STEP_INC = 2'h0;
    localparam logic [1:0] STEP_DEC = 2'h1;

    // target regions on the system bus
    localparam logic [1:0] REG_EXT  = 2'h0;   // external memory
    localparam logic [1:0] REG_IRAM = 2'h1;   // internal ram
    localparam logic [1:0] REG_PIO  = 2'h2;   // on-chip peripheral i/o

    localparam logic [ADDR_W-1:0] STEP_BYTE = 26'h1;
    localparam logic [ADDR_W-1:0] STEP_HALF = 26'h2;
    localparam logic [CNT_W-1:0]  CNT_LAST  = 16'h1;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h1;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} xfer_state_e;
endpackage

/* File: include/dma_buf_if.sv */
// valid/ready carrier between the transfer engine and its two-entry data buffer
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface dma_buf_if #(parameter int W = 16);
    logic         in_valid;   // engine offers a read word
    logic         in_ready;   // buffer has room
    logic [W-1:0] in_data;    // word read from the source
    logic         out_valid;  // buffer holds a word
    logic         out_ready;  // engine consumes the word
    logic [W-1:0] out_data;   // oldest stored word

    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: core/dma_skid_buf.sv */
// two-entry first-in first-out buffer in the read-to-write data path
// assumes the caller honours in_ready and out_valid
`timescale 1ns/100ps
module dma_skid_buf #(
    parameter int DEPTH = 2
) (
    input  wire logic  clock_i,
    input  wire logic  sys_rst_i,
    dma_buf_if.store   bus
);
    localparam int PW = $clog2(DEPTH);

    logic [$bits(bus.in_data)-1:0] mem [DEPTH];   // storage words
    logic [PW-1:0]                 wr_ptr_q;      // next slot to fill
    logic [PW-1:0]                 rd_ptr_q;      // oldest slot
    logic [PW:0]                   fill_q;        // words held
    logic                          push;          // accepted write
    logic                          pop;           // accepted read

    assign push          = bus.in_valid && bus.in_ready;
    assign pop           = bus.out_valid && bus.out_ready;
    // full refuses input, empty hides output
    assign bus.in_ready  = fill_q != (PW+1)'(DEPTH);
    assign bus.out_valid = fill_q != '0;
    assign bus.out_data  = mem[rd_ptr_q];

    // storage has no reset; contents are only read once valid
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_q] <= bus.in_data;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + PW'(1);
            end
        end
    end

    // occupancy count
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fill_q <= '0;
        end else if (push && !pop) begin
            fill_q <= fill_q + (PW+1)'(1);
        end else if (pop && !push) begin
            fill_q <= fill_q - (PW+1)'(1);
        end
    end
endmodule

/* File: core/dma_channel_control.sv */
// four-channel transfer controller: trigger latching, priority, data mover, cpu arbitration
// assumes triggers, configuration strobes and bus answers come from logic on clock_i
//
// Operation
// - enable low halts, keeps address and count
// - enable high resumes from stopped position
// - 16-bit transfers force address lsb low
// - controller beats cpu for shared resources
// - ext-to-pio transfer leaves internal ram free
// - ext-to-ext transfer leaves ram, pio free
// - four independent channels, own registers each
// - completion flag clears when read
// - trigger dropped while pending or busy
`timescale 1ns/100ps
module dma_channel_control #(
    parameter int NUM_CH = dma_pkg::NUM_CH,
    parameter int ADDR_W = dma_pkg::ADDR_W,
    parameter int CNT_W  = dma_pkg::CNT_W,
    parameter int DATA_W = dma_pkg::DATA_W,
    parameter int TRIG_W = dma_pkg::TRIG_W
) (
    input  wire logic                              clock_i,
    input  wire logic                              sys_rst_i,
    // per-channel software control
    input  wire logic [NUM_CH-1:0]                 chan_enable_i,
    input  wire logic [NUM_CH-1:0][TRIG_W-1:0]     trigger_select_i,
    input  wire logic [NUM_CH-1:0]                 complete_read_i,
    // configuration load strobe and values
    input  wire logic                              cfg_write_i,
    input  wire logic [1:0]                        cfg_chan_i,
    input  wire logic [ADDR_W-1:0]                 cfg_source_addr_i,
    input  wire logic [ADDR_W-1:0]                 cfg_dest_addr_i,
    input  wire logic [1:0]                        cfg_source_region_i,
    input  wire logic [1:0]                        cfg_dest_region_i,
    input  wire logic [CNT_W-1:0]                  cfg_transfer_count_i,
    input  wire logic [dma_pkg::CTRL_W-1:0]        cfg_addressing_control_i,
    // peripheral trigger pulses, one per trigger factor
    input  wire logic [(1<<TRIG_W)-1:0]            trigger_i,
    // system bus master port
    input  wire logic                              bus_ack_i,
    input  wire logic [DATA_W-1:0]                 bus_rdata_i,
    output logic                                   bus_req_o,
    output logic                                   bus_write_o,
    output logic                                   bus_wide_o,
    output logic [ADDR_W-1:0]                      bus_addr_o,
    output logic [DATA_W-1:0]                      bus_wdata_o,
    // cpu arbitration
    input  wire logic                              cpu_req_i,
    input  wire logic [1:0]                        cpu_region_i,
    output logic                                   cpu_grant_o,
    // status
    output logic [NUM_CH-1:0]                      request_pending_flag_o,
    output logic [NUM_CH-1:0]                      transfer_complete_flag_o,
    output logic [NUM_CH-1:0]                      chan_busy_o
);
    // per-channel configuration and progress
    logic [ADDR_W-1:0]          src_q    [NUM_CH];   // current source address
    logic [ADDR_W-1:0]          dst_q    [NUM_CH];   // current destination address
    logic [CNT_W-1:0]           cnt_q    [NUM_CH];   // transfers still to do
    logic [dma_pkg::CTRL_W-1:0] ctrl_q   [NUM_CH];   // addressing control word
    logic [1:0]                 sreg_q   [NUM_CH];   // source region
    logic [1:0]                 dreg_q   [NUM_CH];   // destination region
    logic [NUM_CH-1:0]          armed_q;             // loaded and not yet finished
    logic [NUM_CH-1:0]          pend_q;              // latched trigger not yet served
    logic [NUM_CH-1:0]          tc_q;                // transfer block complete
    logic [NUM_CH-1:0]          trig_hit;            // selected trigger fired this cycle
    logic [NUM_CH-1:0]          eligible;            // may be granted now
    dma_pkg::xfer_state_e       state_q;             // mover state
    logic [1:0]                 act_q;               // channel being served
    logic                       grant_any;           // some channel eligible
    logic [1:0]                 grant_ch;            // winning channel
    logic                       done_beat;           // write phase accepted
    logic                       cpu_clash;           // cpu target in use by mover

    dma_buf_if #(.W(DATA_W)) buf_bus ();

    dma_skid_buf #(.DEPTH(2)) u_buf (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .bus       (buf_bus.store)
    );

    // address after one step; fixed mode holds it
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [1:0] mode,
                                                    input logic wide);
        logic [ADDR_W-1:0] inc;
        inc = wide ? dma_pkg::STEP_HALF : dma_pkg::STEP_BYTE;
        if (mode == dma_pkg::STEP_INC) begin
            step_addr = a + inc;
        end else if (mode == dma_pkg::STEP_DEC) begin
            step_addr = a - inc;
        end else begin
            step_addr = a;
        end
    endfunction

    function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                                input logic wide);
        align = wide ? {a[ADDR_W-1:1], 1'b0} : a;
    endfunction

    // trigger match and eligibility per channel
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            trig_hit[c] = trigger_i[trigger_select_i[c]];
            eligible[c] = pend_q[c] && chan_enable_i[c] && armed_q[c];
        end
    end

    always_comb begin
        grant_any = 1'b0;
        grant_ch  = '0;
        for (int c = NUM_CH-1; c >= 0; c--) begin
            if (eligible[c]) begin
                grant_any = 1'b1;
                grant_ch  = 2'(c);
            end
        end
    end

    assign done_beat = (state_q == dma_pkg::ST_WRITE) && bus_req_o && bus_ack_i;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (done_beat && act_q == 2'(c)) begin
                    pend_q[c] <= 1'b0;
                end else if (trig_hit[c] && chan_enable_i[c] && armed_q[c] && !pend_q[c]) begin
                    pend_q[c] <= 1'b1;
                end
            end
        end
    end

    // cleared by read, a same-cycle completion wins
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tc_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (done_beat && act_q == 2'(c) && cnt_q[c] == dma_pkg::CNT_LAST) begin
                    tc_q[c] <= 1'b1;
                end else if (complete_read_i[c]) begin
                    tc_q[c] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            armed_q <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                src_q[c]  <= '0;
                dst_q[c]  <= '0;
                cnt_q[c]  <= '0;
                ctrl_q[c] <= '0;
                sreg_q[c] <= dma_pkg::REG_EXT;
                dreg_q[c] <= dma_pkg::REG_EXT;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (cfg_write_i && cfg_chan_i == 2'(c)) begin
                    src_q[c]   <= cfg_source_addr_i;
                    dst_q[c]   <= cfg_dest_addr_i;
                    cnt_q[c]   <= cfg_transfer_count_i;
                    ctrl_q[c]  <= cfg_addressing_control_i;
                    sreg_q[c]  <= cfg_source_region_i;
                    dreg_q[c]  <= cfg_dest_region_i;
                    armed_q[c] <= 1'b1;
                // progress kept so a resume continues here
                end else if (done_beat && act_q == 2'(c)) begin
                    src_q[c] <= step_addr(src_q[c], ctrl_q[c][dma_pkg::CTRL_SRC_HI:dma_pkg::CTRL_SRC_LO],
                                          ctrl_q[c][dma_pkg::CTRL_WIDE_BIT]);
                    dst_q[c] <= step_addr(dst_q[c], ctrl_q[c][dma_pkg::CTRL_DST_HI:dma_pkg::CTRL_DST_LO],
                                          ctrl_q[c][dma_pkg::CTRL_WIDE_BIT]);
                    cnt_q[c] <= cnt_q[c] - dma_pkg::CNT_ONE;
                    // last transfer ends the block until the next load
                    if (cnt_q[c] == dma_pkg::CNT_LAST) begin
                        armed_q[c] <= 1'b0;
                    end
                end
            end
        end
    end

    // mover: read one word into the buffer, then write it out
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q     <= dma_pkg::ST_IDLE;
            act_q       <= '0;
            bus_req_o   <= 1'b0;
            bus_write_o <= 1'b0;
            bus_wide_o  <= 1'b0;
            bus_addr_o  <= '0;
            bus_wdata_o <= '0;
        end else begin
            unique case (state_q)
                dma_pkg::ST_IDLE: begin
                    // start only with room in the buffer so no read word is lost
                    if (grant_any && buf_bus.in_ready) begin
                        act_q       <= grant_ch;
                        bus_req_o   <= 1'b1;
                        bus_write_o <= 1'b0;
                        bus_wide_o  <= ctrl_q[grant_ch][dma_pkg::CTRL_WIDE_BIT];
                        bus_addr_o  <= align(src_q[grant_ch],
                                             ctrl_q[grant_ch][dma_pkg::CTRL_WIDE_BIT]);
                        state_q     <= dma_pkg::ST_READ;
                    end
                end
                dma_pkg::ST_READ: begin
                    if (bus_ack_i) begin
                        bus_req_o <= 1'b0;
                        state_q   <= dma_pkg::ST_WRITE;
                    end
                end
                dma_pkg::ST_WRITE: begin
                    if (!bus_req_o && buf_bus.out_valid) begin
                        bus_req_o   <= 1'b1;
                        bus_write_o <= 1'b1;
                        bus_wdata_o <= buf_bus.out_data;
                        bus_addr_o  <= align(dst_q[act_q], bus_wide_o);
                    end else if (done_beat) begin
                        bus_req_o   <= 1'b0;
                        bus_write_o <= 1'b0;
                        state_q     <= dma_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // read data enters the buffer on the read answer; the write answer drains it
    assign buf_bus.in_valid  = (state_q == dma_pkg::ST_READ) && bus_ack_i;
    assign buf_bus.in_data   = bus_rdata_i;
    assign buf_bus.out_ready = done_beat;

    // cpu held off the regions the mover is using
    // ext-to-ext leaves ram and pio free
    assign cpu_clash = (state_q != dma_pkg::ST_IDLE) &&
                       (cpu_region_i == sreg_q[act_q] || cpu_region_i == dreg_q[act_q]);

    // grant is registered, so it trails the cpu request by one cycle
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_grant_o <= 1'b0;
        end else begin
            cpu_grant_o <= cpu_req_i && !cpu_clash && !(grant_any && state_q == dma_pkg::ST_IDLE &&
                           (cpu_region_i == sreg_q[grant_ch] || cpu_region_i == dreg_q[grant_ch]));
        end
    end

    // status outputs from flops
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            request_pending_flag_o   <= '0;
            transfer_complete_flag_o <= '0;
            chan_busy_o              <= '0;
        end else begin
            request_pending_flag_o   <= pend_q;
            transfer_complete_flag_o <= tc_q;
            for (int c = 0; c < NUM_CH; c++) begin
                chan_busy_o[c] <= (state_q != dma_pkg::ST_IDLE) && act_q == 2'(c);
            end
        end
    end
endmodule

/* File: verif/dma_channel_control_asserts.sv */
// property checker for the four-channel transfer controller, top ports only
// assumes one clock domain and the bind statement at the foot of this file
`timescale 1ns/100ps
module dma_channel_control_asserts #(
    parameter int NUM_CH = 4,
    parameter int ADDR_W = 26,
    parameter int TRIG_W = 6
) (
    input wire logic                          clock_i,
    input wire logic                          sys_rst_i,
    input wire logic [NUM_CH-1:0]             chan_enable_i,
    input wire logic [NUM_CH-1:0][TRIG_W-1:0] trigger_select_i,
    input wire logic [NUM_CH-1:0]             complete_read_i,
    input wire logic [(1<<TRIG_W)-1:0]        trigger_i,
    input wire logic                          bus_ack_i,
    input wire logic                          bus_req_o,
    input wire logic                          bus_write_o,
    input wire logic                          bus_wide_o,
    input wire logic [ADDR_W-1:0]             bus_addr_o,
    input wire logic                          cpu_req_i,
    input wire logic                          cpu_grant_o,
    input wire logic [NUM_CH-1:0]             request_pending_flag_o,
    input wire logic [NUM_CH-1:0]             transfer_complete_flag_o,
    input wire logic [NUM_CH-1:0]             chan_busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    AST_WIDE_ALIGN: assert property (bus_req_o && bus_wide_o |-> !bus_addr_o[0])
        else $error("odd wide address");
    AST_REQ_STANDS: assert property (bus_req_o && !bus_ack_i |=>
        bus_req_o && $stable(bus_addr_o) && $stable(bus_write_o))
        else $error("request moved early");
    AST_REQ_RELEASE: assert property (bus_req_o && bus_ack_i |=> !bus_req_o)
        else $error("bus not released");
    AST_WRITE_FOLLOWS: assert property (bus_req_o && bus_ack_i && !bus_write_o
        |-> ##2 (bus_req_o && bus_write_o))
        else $error("write late");
    // idle and fully disabled: the mover must stay off the bus
    AST_HALT: assert property ((chan_enable_i == 4'h0 && !bus_req_o
        && chan_busy_o == 4'h0) [*3] |=> !bus_req_o)
        else $error("started while disabled");
    AST_RESUME: assert property ((request_pending_flag_o != 4'h0
        && chan_enable_i == 4'hf) |-> ##[0:40] bus_req_o)
        else $error("pending not served");
    AST_GRANT_OFF: assert property (!cpu_req_i |=> !cpu_grant_o)
        else $error("stray grant");

    // per channel flag timing, two cycles from cause to flag
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        AST_PEND_RISE: assert property ($rose(request_pending_flag_o[c])
            |-> $past(trigger_i[trigger_select_i[c]], 2))
            else $error("pending set without a trigger");
        AST_PEND_FALL: assert property ($fell(request_pending_flag_o[c])
            |-> $past(bus_ack_i && bus_write_o, 2))
            else $error("pending cleared early");
        AST_PEND_DROP: assert property ($fell(request_pending_flag_o[c])
            && !$past(trigger_i[trigger_select_i[c]]) |=> !request_pending_flag_o[c])
            else $error("trigger queued");
        AST_CPL_READ: assert property (complete_read_i[c] && !bus_ack_i
            && !$past(bus_ack_i) ##1 !bus_ack_i |=> !transfer_complete_flag_o[c])
            else $error("flag survived read");
    end

    COV_WRITE: cover property (bus_req_o && bus_ack_i && bus_write_o);
    COV_DONE: cover property ($rose(transfer_complete_flag_o[0]));
    COV_SHARE: cover property (cpu_req_i && bus_req_o ##1 cpu_grant_o);
endmodule

bind dma_channel_control dma_channel_control_asserts #(
    .NUM_CH(NUM_CH), .ADDR_W(ADDR_W), .TRIG_W(TRIG_W)
) u_asserts (.*);

/* File: verif/dma_bus_model.sv */
// system bus responder standing in for memory and peripheral i/o
// assumes each request is held until answered, one answer per request
`timescale 1ns/100ps
module dma_bus_model (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        req_i,    // request level from the controller
    input  wire logic [25:0] addr_i,   // access address
    input  wire logic [3:0]  wait_i,   // extra answer latency in cycles
    output logic             ack_o,    // one-cycle answer
    output logic [15:0]      rdata_o   // read data, valid with ack only
);
    logic [3:0] cnt_q;                 // cycles waited on the current request

    // answer after the commanded wait, then go quiet
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q   <= 4'h0;
            ack_o   <= 1'b0;
            rdata_o <= 16'h0;
        end else if (req_i && !ack_o && cnt_q >= wait_i) begin
            cnt_q   <= 4'h0;
            ack_o   <= 1'b1;
            rdata_o <= addr_i[15:0] ^ 16'ha5c3;
        end else begin
            cnt_q   <= (req_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
            ack_o   <= 1'b0;
            rdata_o <= ~rdata_o;       // stale data alternates between the last word and its inverse
        end
    end
endmodule

/* File: verif/dma_channel_control_tb_top.sv */
// self-checking bench for the four-channel transfer controller
// assumes the bus responder model and the bound property checker
`timescale 1ns/100ps
module dma_channel_control_tb_top;
    logic             clock_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic [3:0]       chan_enable_i = 4'h0;
    logic [3:0][5:0]  trigger_select_i = {6'h1d, 6'h14, 6'h0b, 6'h02}; // distinct
    logic [3:0]       complete_read_i = 4'h0;
    logic             cfg_write_i = 1'b0;
    logic [1:0]       cfg_chan_i = 2'h0, cfg_source_region_i = 2'h0, cfg_dest_region_i = 2'h0;
    logic [25:0]      cfg_source_addr_i = 26'h0, cfg_dest_addr_i = 26'h0;
    logic [15:0]      cfg_transfer_count_i = 16'h0, cfg_addressing_control_i = 16'h0;
    logic [63:0]      trigger_i = 64'h0;
    logic             cpu_req_i = 1'b0;
    logic [1:0]       cpu_region_i = 2'h0;
    logic [3:0]       wait_n = 4'h0;   // responder latency
    logic             bus_ack_i, bus_req_o, bus_write_o, bus_wide_o, cpu_grant_o;
    logic [15:0]      bus_rdata_i, bus_wdata_o;
    logic [25:0]      bus_addr_o, s, d;
    logic [3:0]       request_pending_flag_o, transfer_complete_flag_o, chan_busy_o;
    logic [42:0]      exp_q[$];        // {wide, address, data} of each expected write
    logic [42:0]      e;
    int               fails = 0, comparisons = 0, n;

    always #10 clock_i = ~clock_i;

    dma_channel_control dut (.*);

    dma_bus_model u_mem (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(bus_req_o),
        .addr_i(bus_addr_o), .wait_i(wait_n), .ack_o(bus_ack_i), .rdata_o(bus_rdata_i));

    task automatic err(input string what);
        fails++;
        $display("BAD %0t %s", $time, what);
    endtask

    task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
        comparisons++;
        if (got !== exp) err(what);
    endtask

    task automatic results();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one configuration strobe; settings only change while the channel is idle
    task automatic load(input int ch, input logic [25:0] sa, da, input logic [1:0] sr, dr,
                        input logic [15:0] cnt, ctl);
        @(posedge clock_i);
        cfg_write_i <= 1'b1;
        cfg_chan_i <= 2'(ch);
        cfg_source_addr_i <= sa;
        cfg_dest_addr_i <= da;
        cfg_source_region_i <= sr;
        cfg_dest_region_i <= dr;
        cfg_transfer_count_i <= cnt;
        cfg_addressing_control_i <= ctl;
        @(posedge clock_i);
        cfg_write_i <= 1'b0;
    endtask

    task automatic fire(input logic [63:0] m);
        @(posedge clock_i);
        trigger_i <= m;
        @(posedge clock_i);
        trigger_i <= 64'h0;
    endtask

    // bounded wait until idle; two edges first so a fresh trigger shows
    task automatic wait_idle();
        n = 0;
        repeat (2) @(posedge clock_i);
        while (bus_req_o !== 1'b0 || chan_busy_o !== 4'h0 || request_pending_flag_o !== 4'h0) begin
            @(posedge clock_i);
            n++;
            if (n > 400) begin
                err("wait ran out");
                results();
            end
        end
        repeat (2) @(posedge clock_i);
    endtask

    // each write answer against the oldest note; byte data unchecked
    always @(posedge clock_i) begin
        if (bus_req_o === 1'b1 && bus_write_o === 1'b1 && bus_ack_i === 1'b1) begin
            if (exp_q.size() == 0) err("unexpected write");
            else begin
                e = exp_q.pop_front();
                comparisons++;
                if (bus_addr_o !== e[41:16] || bus_wide_o !== e[42]
                    || (e[42] && bus_wdata_o !== e[15:0]))
                    err("write address or data wrong");
            end
        end
    end

    initial begin
        void'($urandom(58469));
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        chan_enable_i <= 4'hf;
        // all four triggered at once: odd addresses, wide on even channels
        for (int c = 0; c < 4; c++) begin
            s = 26'h0100001 + 26'($urandom_range(0, 4095) * 16); // inside external memory
            d = 26'h0200001 + 26'(c * 16);
            load(c, s, d, 2'h0, 2'h0, 16'h1, {1'b0, ~c[0], 14'h0});
            exp_q.push_back({~c[0], c[0] ? d : {d[25:1], 1'b0}, {s[15:1], 1'b0} ^ 16'ha5c3});
        end
        fire(64'h0000_0000_2010_0804);
        wait_idle();
        @(negedge clock_i);
        check(transfer_complete_flag_o, 4'hf, "not all channels complete");
        @(posedge clock_i);
        complete_read_i <= 4'h5;
        @(posedge clock_i);
        complete_read_i <= 4'h0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check(transfer_complete_flag_o, 4'ha, "read did not clear completion");
        @(posedge clock_i);
        // three wide steps, paused and resumed after the first
        wait_n <= 4'($urandom_range(0, 4));
        chan_enable_i <= 4'h1;
        s = 26'h0100001 + 26'($urandom_range(0, 4095) * 16);
        load(0, s, 26'h0080041, 2'h0, 2'h1, 16'h3, 16'h4010);
        for (int k = 0; k < 3; k++)
            exp_q.push_back({1'b1, 26'h0080040 - 26'(2 * k),
                             (s[15:0] - 16'h1 + 16'(2 * k)) ^ 16'ha5c3});
        fire(64'h4);
        fire(64'h4);
        wait_idle();
        check(4'(exp_q.size()), 4'h2, "dropped trigger made a write");
        chan_enable_i <= 4'h0;
        repeat (6) @(posedge clock_i);
        chan_enable_i <= 4'h1;
        for (int k = 1; k < 3; k++) begin
            fire(64'h4);
            wait_idle();
        end
        @(negedge clock_i);
        check(transfer_complete_flag_o, 4'hb, "count lost across pause");
        @(posedge clock_i);
        // slow bus: cpu grant per region
        wait_n <= 4'h6;
        chan_enable_i <= 4'hf;
        for (int j = 1; j < 3; j++) begin
            d = (j == 1) ? 26'h0001001 : 26'h0300001;
            load(j, 26'h0100021, d, 2'h0, (j == 1) ? 2'h2 : 2'h0, 16'h1, 16'h0);
            exp_q.push_back({1'b0, d, 16'h0});
            fire((j == 1) ? 64'h800 : 64'h100000);
            n = 0;
            while (bus_req_o !== 1'b1 && n < 50) begin
                @(posedge clock_i);
                n++;
            end
            if (n == 50) begin
                err("no bus request");
                results();
            end
            for (int r = 0; r < 3; r++) begin
                cpu_req_i <= 1'b1;
                cpu_region_i <= 2'(r);
                @(posedge clock_i);
                @(negedge clock_i);
                check({3'h0, cpu_grant_o}, {3'h0, r == 1 || (j == 2 && r == 2)}, "grant");
                @(posedge clock_i);
            end
            wait_idle();
            cpu_region_i <= 2'h0;
            @(posedge clock_i);
            @(negedge clock_i);
            check({3'h0, cpu_grant_o}, 4'h1, "bus not handed back");
            @(posedge clock_i);
            cpu_req_i <= 1'b0;
        end
        results();
    end
endmodule
